// *** verilog/bcr_defines.svh ***
// Purpose: Offsets, field positions, masks and reset values of the
//          bridge command register and its status half.
// Assumes: Included by bare name wherever the values are needed.
// Notes:   Definitions only.
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH

// Byte offset of the dword that holds command and status
`define BCR_CMD_OFFSET 8'h04

// Command field positions
`define BCR_IO_EN_BIT 0
`define BCR_MEM_EN_BIT 1
`define BCR_MASTER_EN_BIT 2
`define BCR_PARITY_EN_BIT 6
`define BCR_SYSERR_EN_BIT 8
`define BCR_INT_DIS_BIT 10

// Writable command bits: 0, 1, 2, 6, 8, 10
`define BCR_CMD_WMASK 16'h0547
`define BCR_CMD_RESET 16'h0000

// Status half positions (dword bit minus 16)
`define BCR_STAT_CAPLIST_BIT 4
`define BCR_STAT_MDPE_BIT 8
`define BCR_STAT_SSE_BIT 14
`define BCR_STAT_DPE_BIT 15
`define BCR_STAT_FIXED 16'h0010
`define BCR_STAT_RESET 1'b0

`endif

// *** verilog/bcr_pkg.sv ***
// Purpose: Types shared by the bridge command register files.
// Assumes: Constants live in bcr_defines.svh.
// Notes:   Types only.
`default_nettype none
package bcr_pkg;
    typedef logic [15:0] bcr_half_t;
    typedef logic [31:0] bcr_dword_t;
    typedef logic [7:0] bcr_addr_t;
    typedef logic [3:0] bcr_be_t;
endpackage
`default_nettype wire

// *** verilog/bcr_status_flag.sv ***
// Purpose: One sticky status flag, set by hardware, cleared by writing one.
// Assumes: Set and clear are single-cycle terms on sys_clk.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

module bcr_status_flag
    import bcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic setPulse,
    input wire logic clrPulse,
    output logic flagQ
);

    ////////////////////////////////////////////////////////////////////////
    // Sticky flag, set has priority over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagQ <= `BCR_STAT_RESET;
        end else if (clkEn) begin
            if (setPulse) begin
                flagQ <= 1'b1;
            end else if (clrPulse) begin
                flagQ <= 1'b0;
            end
        end
    end

endmodule // bcr_status_flag
`default_nettype wire

// *** verilog/bcr_command.sv ***
// Purpose: Command register of the bridge configuration header, the gates
//          it drives, and the three error flags of its status half.
// Assumes: Configuration requests and all event inputs come from logic on
//          sys_clk; addresses are byte addresses of whole dwords.
// Notes:   Reads return data one cycle after the request.
//
// How it works
// - I/O requests on the primary side are answered only while bit 0 is set.
// - Memory requests on the primary side are answered only while bit 1 is set.
// - With bit 2 clear no upstream request is started and downstream ones are refused.
// - A refused non-posted downstream request gets an Unsupported Request completion.
// - With bit 2 set downstream memory and I/O requests are forwarded upstream.
// - Bits 3, 4, 5, 7 and 9 read as zero and ignore writes.
// - With bit 6 clear detected parity errors may be ignored.
// - With bit 6 set every detected parity error gets its normal handling.
// - Bit 8 gates fatal and non-fatal error messages to the root complex.
// - Bit 10 set stops the block's own INTx messages.
// - INTx messages forwarded from downstream pass whatever bit 10 holds.
// - Status bit 30 sets when an error message is sent with bit 8 set.
// - Status bit 24 never sets while bit 6 is clear.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defines.svh"

module bcr_command
    import bcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire bcr_addr_t cfgAddr,
    input wire bcr_be_t cfgByteEn,
    input wire bcr_dword_t cfgWrData,
    output bcr_dword_t cfgRdData,
    output logic cfgRdValid,
    input wire logic inIoReq,
    input wire logic inMemReq,
    output logic ioAccept,
    output logic memAccept,
    input wire logic localMasterReq,
    output logic localMasterGrant,
    input wire logic dnReqValid,
    input wire logic dnReqNonPosted,
    output logic dnForward,
    output logic dnUrComplete,
    input wire logic parityErrDetected,
    input wire logic parityErrMaster,
    output logic parityActionReq,
    input wire logic poisonedRx,
    input wire logic errMsgReq,
    output logic errMsgSend,
    input wire logic localIntReq,
    output logic intxSend,
    input wire logic dnIntxReq,
    output logic intxForward,
    output bcr_half_t commandQ
);

    bcr_half_t statusHalf;
    logic hitCmd;
    logic ioSpaceEnable;
    logic memSpaceEnable;
    logic busMasterEnable;
    logic parityRespEnable;
    logic system_error_report_enable;
    logic intxDisable;
    logic [2:0] flagSet;
    logic [2:0] flagClr;
    logic [2:0] flagQ;
    bcr_half_t cmdWMask;

    ////////////////////////////////////////////////////////////////////////
    // Decode and named command fields
    assign hitCmd = (cfgAddr == `BCR_CMD_OFFSET);
    assign cmdWMask = `BCR_CMD_WMASK; // Per-lane slices avoid width loss
    assign ioSpaceEnable = commandQ[`BCR_IO_EN_BIT];
    assign memSpaceEnable = commandQ[`BCR_MEM_EN_BIT];
    assign busMasterEnable = commandQ[`BCR_MASTER_EN_BIT];
    assign parityRespEnable = commandQ[`BCR_PARITY_EN_BIT];
    assign system_error_report_enable = commandQ[`BCR_SYSERR_EN_BIT];
    assign intxDisable = commandQ[`BCR_INT_DIS_BIT];

    // Command write, byte lanes 0 and 1; fixed bits never stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            commandQ <= `BCR_CMD_RESET;
        end else if (clkEn && cfgWrEn && hitCmd) begin
            if (cfgByteEn[0]) begin
                commandQ[7:0] <= cfgWrData[7:0] & cmdWMask[7:0];
            end
            if (cfgByteEn[1]) begin
                commandQ[15:8] <= cfgWrData[15:8]
                    & cmdWMask[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Primary-side target gates
    assign ioAccept = inIoReq && ioSpaceEnable;
    assign memAccept = inMemReq && memSpaceEnable;

    // Upstream mastering and downstream request handling
    assign localMasterGrant = localMasterReq && busMasterEnable;
    assign dnForward = dnReqValid && busMasterEnable;
    assign dnUrComplete = dnReqValid && !busMasterEnable
        && dnReqNonPosted;

    // Parity handling follows the response enable
    assign parityActionReq = parityErrDetected && parityRespEnable;

    // Error messages gated by the report enable
    assign errMsgSend = errMsgReq && system_error_report_enable;

    // Own INTx gated, forwarded INTx untouched
    assign intxSend = localIntReq && !intxDisable;
    assign intxForward = dnIntxReq;

    ////////////////////////////////////////////////////////////////////////
    // Status flags: 0 master parity, 1 signalled error, 2 poisoned receipt
    assign flagSet[0] = parityErrDetected && parityErrMaster
        && parityRespEnable;
    assign flagSet[1] = errMsgSend;
    assign flagSet[2] = poisonedRx;
    assign flagClr[0] = cfgWrEn && hitCmd && cfgByteEn[3]
        && cfgWrData[16 + `BCR_STAT_MDPE_BIT];
    assign flagClr[1] = cfgWrEn && hitCmd && cfgByteEn[3]
        && cfgWrData[16 + `BCR_STAT_SSE_BIT];
    assign flagClr[2] = cfgWrEn && hitCmd && cfgByteEn[3]
        && cfgWrData[16 + `BCR_STAT_DPE_BIT];

    // One sticky flag per status bit
    generate
        for (genvar i = 0; i < 3; i++) begin : g_flag
            bcr_status_flag u_flag (
                .sys_clk(sys_clk),
                .rst(rst),
                .clkEn(clkEn),
                .setPulse(flagSet[i]),
                .clrPulse(flagClr[i]),
                .flagQ(flagQ[i])
            );
        end
    endgenerate

    // Status half image
    always_comb begin
        statusHalf = `BCR_STAT_FIXED;
        statusHalf[`BCR_STAT_MDPE_BIT] = flagQ[0];
        statusHalf[`BCR_STAT_SSE_BIT] = flagQ[1];
        statusHalf[`BCR_STAT_DPE_BIT] = flagQ[2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfgRdData <= 32'h0000_0000;
            cfgRdValid <= 1'b0;
        end else if (clkEn) begin
            cfgRdValid <= cfgRdEn;
            if (cfgRdEn) begin
                cfgRdData <= hitCmd ? {statusHalf, commandQ} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_cmdWrite;
        clkEn && cfgWrEn && hitCmd && cfgByteEn[0];
    endsequence

    sequence s_cmdRead;
        clkEn && cfgRdEn && hitCmd && !cfgWrEn;
    endsequence

    a_io_gate: assert property (ioAccept == (inIoReq && commandQ[0]))
        else $error("I/O accept disagrees with bit 0");
    a_mem_write: assert property (s_cmdWrite |=>
        commandQ[1] == $past(cfgWrData[1]))
        else $error("Memory enable not taken from write");
    a_master_off: assert property (!commandQ[2] |->
        !localMasterGrant && !dnForward)
        else $error("Traffic passed with mastering off");
    a_ur_answer: assert property (dnReqValid && dnReqNonPosted
        && !commandQ[2] |-> dnUrComplete)
        else $error("Refused request got no UR completion");
    a_fwd_up: assert property (dnReqValid && commandQ[2]
        |-> dnForward && !dnUrComplete)
        else $error("Request not forwarded upstream");
    a_fixed_zero: assert property (s_cmdWrite ##[1:2] s_cmdRead |=>
        cfgRdValid
        && cfgRdData[15:0] == (cfgRdData[15:0] & `BCR_CMD_WMASK))
        else $error("Fixed command bit read nonzero");
    a_rd_fixed: assert property (clkEn && cfgRdEn && hitCmd |=>
        (cfgRdData[15:0] & ~cmdWMask) == 16'h0000)
        else $error("Fixed command bit read back nonzero");
    a_parity_act: assert property (parityErrDetected |->
        parityActionReq == commandQ[6])
        else $error("Parity action ignores enable");
    a_err_gate: assert property (errMsgSend |-> errMsgReq && commandQ[8])
        else $error("Error message sent while disabled");
    a_intx_gate: assert property (commandQ[10] |-> !intxSend)
        else $error("Own INTx sent while disabled");
    a_intx_fwd: assert property (dnIntxReq |-> intxForward)
        else $error("Forwarded INTx blocked");
    a_reset_zero: assert property (disable iff (1'b0)
        $past(rst) |-> commandQ == 16'h0000)
        else $error("Command not zero after reset");
    a_sse_set: assert property (clkEn && errMsgSend |=> flagQ[1])
        else $error("Signalled error flag not set");
    a_mdpe_gate: assert property ($rose(flagQ[0]) |->
        $past(commandQ[6]))
        else $error("Parity flag set with response off");

endmodule // bcr_command
`default_nettype wire

// *** tb/bcr_root_model.sv ***
// Purpose: Root complex model issuing configuration writes and reads.
// Assumes: Requests launch at the falling edge of sys_clk.
// Notes:   Released address, byte-enable and data lines show the inverse of their last value; both enables go low.
`timescale 1ns/10ps
`default_nettype none

module bcr_root_model
    import bcr_pkg::*;
(
    input wire logic sys_clk,
    output logic cfgWrEn,
    output logic cfgRdEn,
    output bcr_addr_t cfgAddr,
    output bcr_be_t cfgByteEn,
    output bcr_dword_t cfgWrData
);
    // Idle bus at time zero
    initial begin
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = 8'h00;
        cfgByteEn = 4'h0;
        cfgWrData = 32'h0000_0000;
    end

    // One request for one cycle; lines never keep a stale value
    task automatic req(input logic w, input bcr_addr_t a, input bcr_be_t be,
                       input bcr_dword_t d);
        @(negedge sys_clk);
        cfgWrEn = w;
        cfgRdEn = ~w;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWrData = d;
        @(negedge sys_clk);
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = ~a;
        cfgByteEn = ~be;
        cfgWrData = ~d;
    endtask
endmodule // bcr_root_model
`default_nettype wire

// *** tb/test_bridge_command_register.sv ***
// Purpose: Self-checking bench for the bridge command register.
// Assumes: Inputs change at the falling edge; model updates at the rising.
// Notes:   Every cycle compares all outputs against the model.
`timescale 1ns/10ps
`default_nettype none

module test_bridge_command_register;
    import bcr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic [10:0] ev = 11'h000;
    logic cfgWrEn, cfgRdEn, cfgRdValid, ioAccept, memAccept;
    logic localMasterGrant, dnForward, dnUrComplete, parityActionReq;
    logic errMsgSend, intxSend, intxForward, rv;
    bcr_addr_t cfgAddr;
    bcr_be_t cfgByteEn;
    bcr_dword_t cfgWrData, cfgRdData, rd;
    bcr_half_t commandQ;
    logic [15:0] cmd, st;
    logic [31:0] seed = 32'h0000_6950;
    int n_fail = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    bcr_root_model bcr_root_model_i (.sys_clk(sys_clk), .cfgWrEn(cfgWrEn),
        .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWrData(cfgWrData));

    bcr_command bcr_command_i (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .inIoReq(ev[0]), .inMemReq(ev[1]),
        .ioAccept(ioAccept), .memAccept(memAccept), .localMasterReq(ev[2]),
        .localMasterGrant(localMasterGrant), .dnReqValid(ev[3]),
        .dnReqNonPosted(ev[4]), .dnForward(dnForward),
        .dnUrComplete(dnUrComplete), .parityErrDetected(ev[5]),
        .parityErrMaster(ev[6]), .parityActionReq(parityActionReq),
        .poisonedRx(ev[7]), .errMsgReq(ev[8]), .errMsgSend(errMsgSend),
        .localIntReq(ev[9]), .intxSend(intxSend), .dnIntxReq(ev[10]),
        .intxForward(intxForward), .commandQ(commandQ));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic ck(input bit bad, input string m);
        compares++;
        if (bad) begin
            n_fail++;
            $display("Error at %0t: %s mismatch", $time, m);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Model of command bits, sticky flags and the read port
    always @(posedge sys_clk) begin
        logic wr04;
        logic [15:0] set;
        wr04 = cfgWrEn & (cfgAddr == 8'h04);
        set = 16'h0000;
        set[8] = ev[5] & ev[6] & cmd[6];
        set[14] = ev[8] & cmd[8];
        set[15] = ev[7];
        if (rst) begin
            cmd = 16'h0000;
            st = 16'h0000;
            rv = 1'b0;
            rd = 32'h0000_0000;
        end else if (clkEn) begin
            rv = cfgRdEn;
            if (cfgRdEn)
                rd = (cfgAddr == 8'h04) ? {st | 16'h0010, cmd} : 32'h0;
            if (wr04 & cfgByteEn[3])
                st = st & ~(cfgWrData[31:16] & 16'hc100);
            st = st | set;
            if (wr04 & cfgByteEn[0])
                cmd[7:0] = cfgWrData[7:0] & 8'h47;
            if (wr04 & cfgByteEn[1])
                cmd[15:8] = cfgWrData[15:8] & 8'h05;
        end
    end

    // Random side inputs and clock enable, then compare every output
    always @(negedge sys_clk) begin
        seed = xs(seed);
        ev = seed[10:0];
        clkEn = (seed[15:12] != 4'h0);
        #1;
        ck(commandQ !== cmd, "command");
        ck(cfgRdValid !== rv, "read valid");
        ck(cfgRdData !== rd, "read data");
        ck(ioAccept !== (ev[0] & cmd[0]), "io gate");
        ck(memAccept !== (ev[1] & cmd[1]), "mem gate");
        ck(localMasterGrant !== (ev[2] & cmd[2]), "grant");
        ck(dnForward !== (ev[3] & cmd[2]), "forward");
        ck(dnUrComplete !== (ev[3] & ev[4] & ~cmd[2]), "ur");
        ck(parityActionReq !== (ev[5] & cmd[6]), "parity");
        ck(errMsgSend !== (ev[8] & cmd[8]), "error msg");
        ck(intxSend !== (ev[9] & ~cmd[10]), "intx");
        ck(intxForward !== ev[10], "intx forward");
    end

    // Fixed accesses, then random traffic with a reset in mid-run
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        bcr_root_model_i.req(1'b0, 8'h04, 4'h0, 32'h0);
        bcr_root_model_i.req(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
        bcr_root_model_i.req(1'b0, 8'h04, 4'h0, 32'h0);
        bcr_root_model_i.req(1'b1, 8'h08, 4'hf, 32'h0);
        bcr_root_model_i.req(1'b0, 8'h08, 4'h0, 32'h0);
        $display("test done: fixed accesses");
        for (int i = 0; i < 400; i++) begin
            bcr_root_model_i.req(seed[20], seed[21] ? 8'h04 : seed[31:24],
                seed[25:22], seed ^ (seed << 7));
            if (i == 200) begin
                rst = 1'b1;
                repeat (2) @(negedge sys_clk);
                rst = 1'b0;
                $display("test done: first random half and reset");
            end
        end
        $display("test done: random traffic");
        print_verdict();
    end
endmodule // test_bridge_command_register
`default_nettype wire
